/* src/srms_top.v */
// Reset sequencer and configuration strap capture with register access
`timescale 1ns/100ps
`default_nettype none
`include "srms_consts.vh"
module srms_top #(
  parameter ADDR_W = 4
)(
  input wire sys_clk,
  input wire rst_n,
  input wire fundamental_reset_n,
  input wire reset_halt_request,
  input wire [3:0] switch_mode_strap,
  input wire ref_clock_freq_select,
  input wire [1:0] port_clocking_mode_strap,
  input wire [3:0] stack_two_config_strap,
  input wire [4:0] stack_three_config_strap,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire core_reset_n,
  output wire smbus_enable,
  output wire reg_access_enable,
  output wire quasi_reset,
  output reg ref_clock_125_sel,
  output reg [1:0] port_clocking_mode,
  output reg [3:0] stack_two_config,
  output reg [4:0] stack_three_config,
  output reg eeprom_init,
  output reg eeprom_jump_en,
  output reg eeprom_jump_sel,
  output reg reduced_latency,
  output reg multi_partition,
  output reg ports_unattached,
  output reg ports_disabled,
  output reg i2c_reset_mode,
  output reg mode_reserved,
  output wire strap_change_err
);
  localparam [1:0] ST_RESET = 2'h0;
  localparam [1:0] ST_CAPTURE = 2'h1;
  localparam [1:0] ST_HALT = 2'h2;
  localparam [1:0] ST_RUN = 2'h3;

  wire fund_s;
  wire [`SRMS_STRAP_W-1:0] strap_raw;
  wire [`SRMS_STRAP_W-1:0] strap_s;
  wire [`SRMS_DEC_W-1:0] dec;
  wire acc_en;
  wire bus_req;
  wire wr_go;
  wire wr_ctl;
  wire clr_halt;
  wire clr_serr;
  wire mode_moved;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`SRMS_STRAP_W-1:0] cap_q;
  reg halt_q;
  reg serr_q;
  reg ack_q;
  reg [31:0] rd_d;
  reg core_run_q;
  reg quasi_q;
  reg smb_en_q;

  // Pin levels into the clock domain
  assign strap_raw = {reset_halt_request,
                      stack_three_config_strap,
                      stack_two_config_strap,
                      port_clocking_mode_strap,
                      ref_clock_freq_select,
                      switch_mode_strap};

  srms_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_fund_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(fundamental_reset_n),
    .sync_out(fund_s)
  );

  srms_sync #(
    .W(`SRMS_STRAP_W),
    .RST_VAL(`SRMS_STRAP_RST)
  ) u_strap_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(strap_raw),
    .sync_out(strap_s)
  );

  // Sequencer
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:
      begin
        state_d = ST_CAPTURE;
      end
      ST_CAPTURE:
      begin
        if (strap_s[`SRMS_F_HALT])
          state_d = ST_HALT;
        else
          state_d = ST_RUN;
      end
      ST_HALT:
      begin
        if (!halt_q)
          state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
    if (!fund_s)
      state_d = ST_RESET;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_RESET;
    else
      state_q <= state_d;
  end

  // Reset and enable outputs come from flip-flops, so a state change cannot glitch them
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_run_q <= 1'b0;
      quasi_q <= 1'b0;
      smb_en_q <= 1'b0;
    end
    else
    begin
      core_run_q <= (state_d == ST_RUN);
      quasi_q <= (state_d == ST_HALT);
      smb_en_q <= (state_d == ST_HALT) || (state_d == ST_RUN);
    end
  end

  // Internal logic is held in reset until normal operation
  assign core_reset_n = core_run_q;
  assign quasi_reset = quasi_q;
  assign smbus_enable = smb_en_q;
  assign acc_en = smb_en_q;
  assign reg_access_enable = acc_en;

  // Strap capture at reset release
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_q <= `SRMS_STRAP_RST;
    else if (!fund_s)
      cap_q <= `SRMS_STRAP_RST;
    else if (state_q == ST_CAPTURE)
      cap_q <= strap_s;
  end

  srms_mode_dec u_dec (
    .mode_code(cap_q[`SRMS_F_MODE]),
    .dec(dec)
  );

  // Configuration outputs from captured values only
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_clock_125_sel <= 1'b0;
      port_clocking_mode <= 2'h0;
      stack_two_config <= 4'h0;
      stack_three_config <= 5'h00;
      eeprom_init <= 1'b0;
      eeprom_jump_en <= 1'b0;
      eeprom_jump_sel <= 1'b0;
      reduced_latency <= 1'b0;
      multi_partition <= 1'b0;
      ports_unattached <= 1'b0;
      ports_disabled <= 1'b0;
      i2c_reset_mode <= 1'b0;
      mode_reserved <= 1'b0;
    end
    else
    begin
      ref_clock_125_sel <= cap_q[`SRMS_F_FSEL];
      port_clocking_mode <= cap_q[`SRMS_F_CLKM];
      stack_two_config <= cap_q[`SRMS_F_STK2];
      stack_three_config <= cap_q[`SRMS_F_STK3];
      eeprom_init <= dec[0];
      eeprom_jump_en <= dec[1];
      eeprom_jump_sel <= dec[2];
      reduced_latency <= dec[3];
      multi_partition <= dec[4];
      ports_unattached <= dec[5];
      ports_disabled <= dec[6];
      i2c_reset_mode <= dec[7];
      mode_reserved <= dec[8];
    end
  end

  // Register slave, one wait cycle per access
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign wr_ctl = wr_go && acc_en && avs_byteenable[0]
                  && (avs_address == `SRMS_OFF_CTL);
  assign clr_halt = wr_ctl && !avs_writedata[`SRMS_CTL_HALT];
  assign clr_serr = wr_ctl && avs_writedata[`SRMS_CTL_SERR];

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req && !ack_q;
  end

  // Halt bit: set on entering quasi-reset, cleared by software
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      halt_q <= 1'b0;
    else if (!fund_s)
      halt_q <= 1'b0;
    else if ((state_q == ST_CAPTURE) && strap_s[`SRMS_F_HALT])
      halt_q <= 1'b1;
    else if (clr_halt)
      halt_q <= 1'b0;
  end

  // Sticky flag for switch-mode straps moving after capture
  assign mode_moved = acc_en
                      && (strap_s[`SRMS_F_MODE] != cap_q[`SRMS_F_MODE]);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      serr_q <= 1'b0;
    else if (!fund_s)
      serr_q <= 1'b0;
    else if (mode_moved)
      serr_q <= 1'b1;
    else if (clr_serr)
      serr_q <= 1'b0;
  end

  assign strap_change_err = serr_q;

  // Read multiplexer
  always @*
  begin
    rd_d = 32'h0000_0000;
    if (avs_address == `SRMS_OFF_CTL)
    begin
      rd_d[`SRMS_CTL_HALT] = halt_q;
      rd_d[`SRMS_CTL_SERR] = serr_q;
    end
    else if (avs_address == `SRMS_OFF_STRAP)
    begin
      rd_d[`SRMS_STRAP_W-1:0] = cap_q;
    end
    else if (avs_address == `SRMS_OFF_MODE)
    begin
      rd_d[`SRMS_DEC_W-1:0] = dec;
    end
    else if (avs_address == `SRMS_OFF_STAT)
    begin
      rd_d[1:0] = state_q;
      rd_d[2] = core_reset_n;
      rd_d[3] = smbus_enable;
      rd_d[4] = fund_s;
    end
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_q)
      avs_readdata <= rd_d;
  end
endmodule
`default_nettype wire

/* src/srms_consts.vh */
// Constants for the switch reset and mode strap block
// How it works
// - Fundamental reset holds all internal logic reset
// - Halt request keeps quasi-reset with SMBus active
// - Registers readable and writable during quasi-reset
// - Clearing halt bit starts normal operation
// - Codes 0x0/0x1 single partition, optional EEPROM
// - Codes 0x2/0x3 EEPROM from jump 0/1
// - Codes 0x8/0x9 reduced latency, optional EEPROM
// - Codes 0xA/0xB multi-partition, unattached ports
// - Code 0xD unattached, I2C reset, EEPROM
// - Codes 0xE/0xF multi-partition, disabled ports
// - Frequency select 0 means 100, 1 means 125 MHz
// - Clock-mode strap picks port clocking mode
// - Stack two strap picks its lane configuration
// - Stack three strap picks its lane configuration
`ifndef SRMS_CONSTS_VH
`define SRMS_CONSTS_VH

// Register byte offsets
`define SRMS_OFF_CTL 4'h0
`define SRMS_OFF_STRAP 4'h4
`define SRMS_OFF_MODE 4'h8
`define SRMS_OFF_STAT 4'hc

// Control register fields and reset value
`define SRMS_CTL_HALT 0
`define SRMS_CTL_SERR 1
`define SRMS_CTL_RST 32'h0000_0000

// Packed strap vector fields
`define SRMS_STRAP_W 17
`define SRMS_F_MODE 3:0
`define SRMS_F_FSEL 4
`define SRMS_F_CLKM 6:5
`define SRMS_F_STK2 10:7
`define SRMS_F_STK3 15:11
`define SRMS_F_HALT 16
`define SRMS_STRAP_RST 17'h0_0000

// Switch mode codes
`define SRMS_M_SP 4'h0
`define SRMS_M_SP_EE 4'h1
`define SRMS_M_SP_J0 4'h2
`define SRMS_M_SP_J1 4'h3
`define SRMS_M_SP_RL 4'h8
`define SRMS_M_SP_RL_EE 4'h9
`define SRMS_M_MP_UA 4'ha
`define SRMS_M_MP_UA_EE 4'hb
`define SRMS_M_RSV_C 4'hc
`define SRMS_M_MP_UA_I2C 4'hd
`define SRMS_M_MP_DIS 4'he
`define SRMS_M_MP_DIS_EE 4'hf

// Decoded mode vector width
`define SRMS_DEC_W 9

`endif

/* src/srms_sync.v */
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
module srms_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
)(
  input wire sys_clk,
  input wire rst_n,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* src/srms_mode_dec.v */
// Decoder of the switch-mode strap code
`timescale 1ns/100ps
`default_nettype none
`include "srms_consts.vh"
module srms_mode_dec (
  input wire [3:0] mode_code,
  output reg [`SRMS_DEC_W-1:0] dec
);
  // dec: {rsv, i2c, dis, unatt, multi, rl, jsel, jump, ee}
  always @*
  begin
    dec = {`SRMS_DEC_W{1'b0}};
    case (mode_code)
      `SRMS_M_SP: dec = 9'h000;
      `SRMS_M_SP_EE: dec = 9'h001;
      `SRMS_M_SP_J0: dec = 9'h003;
      `SRMS_M_SP_J1: dec = 9'h007;
      `SRMS_M_SP_RL: dec = 9'h008;
      `SRMS_M_SP_RL_EE: dec = 9'h009;
      `SRMS_M_MP_UA: dec = 9'h030;
      `SRMS_M_MP_UA_EE: dec = 9'h031;
      `SRMS_M_MP_UA_I2C: dec = 9'h0b1;
      `SRMS_M_MP_DIS: dec = 9'h050;
      `SRMS_M_MP_DIS_EE: dec = 9'h051;
      `SRMS_M_RSV_C: dec = 9'h100;
      default: dec = 9'h100;
    endcase
  end
endmodule
`default_nettype wire

/* tb/srms_chk.sv */
// Checker on the reset sequencer and strap capture ports
`timescale 1ns/100ps
`default_nettype none
module srms_chk #(
  parameter ADDR_W = 4
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fundamental_reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic core_reset_n,
  input wire logic smbus_enable,
  input wire logic quasi_reset,
  input wire logic [3:0] stack_two_config,
  input wire logic eeprom_init,
  input wire logic eeprom_jump_en,
  input wire logic reduced_latency,
  input wire logic multi_partition,
  input wire logic ports_unattached,
  input wire logic ports_disabled,
  input wire logic i2c_reset_mode,
  input wire logic mode_reserved
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_fund_hold;
    !fundamental_reset_n [*4] |-> !core_reset_n && !smbus_enable;
  endproperty
  a_fund_hold: assert property (p_fund_hold) else $error("core not held");
  property p_quasi;
    quasi_reset |-> !core_reset_n && smbus_enable;
  endproperty
  a_quasi: assert property (p_quasi) else $error("bad quasi state");
  sequence s_clear_halt;
    quasi_reset && avs_write && !avs_waitrequest && avs_address == '0
      && avs_byteenable[0] && !avs_writedata[0];
  endsequence
  property p_halt_exit;
    s_clear_halt |-> ##[1:3] (core_reset_n || !smbus_enable);
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("no run");
  property p_halt_hold;
    quasi_reset && !avs_write && !$past(avs_write) |=> quasi_reset || !smbus_enable;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("left halt");
  property p_cfg_stable;
    core_reset_n && $past(core_reset_n, 2) |-> $stable(stack_two_config);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config moved");
  property p_rsv;
    mode_reserved |-> !(eeprom_init || multi_partition || reduced_latency);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mode");
  property p_jump;
    eeprom_jump_en |-> eeprom_init && !multi_partition && !reduced_latency;
  endproperty
  a_jump: assert property (p_jump) else $error("bad jump");
  property p_mp;
    ports_unattached || ports_disabled || i2c_reset_mode |-> multi_partition
      && !reduced_latency && !(ports_unattached && ports_disabled);
  endproperty
  a_mp: assert property (p_mp) else $error("bad partition");
endmodule
`default_nettype wire

/* tb/srms_board.sv */
// Board strap wiring model
`timescale 1ns/100ps
`default_nettype none
module srms_board (
  input wire logic sys_clk,
  input wire logic hold_n,
  input wire logic mode_live,
  input wire logic [16:0] cfg,
  output var logic fundamental_reset_n,
  output var logic reset_halt_request,
  output var logic [3:0] switch_mode_strap,
  output var logic ref_clock_freq_select,
  output var logic [1:0] port_clocking_mode_strap,
  output var logic [3:0] stack_two_config_strap,
  output var logic [4:0] stack_three_config_strap
);
  always @(posedge sys_clk)
  begin
    fundamental_reset_n <= hold_n;
    {reset_halt_request, stack_three_config_strap, stack_two_config_strap,
      port_clocking_mode_strap, ref_clock_freq_select} <= cfg[16:4];
    // Mode straps move only in reset, unless a test breaks the rule on purpose
    if (!hold_n || mode_live)
      switch_mode_strap <= cfg[3:0];
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Bench for the reset sequencer and strap capture block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = '0, rst_n = '0, hold_n = '0, avs_read = '0, avs_write = '0;
  logic mode_live = '0;
  logic [16:0] cfg = '0;
  logic [3:0] avs_address = '0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0, rd;
  logic [8:0] tbl [16];
  int num_errors = 0, checks_done = 0;
  wire fundamental_reset_n, reset_halt_request, ref_clock_freq_select, avs_waitrequest;
  wire [3:0] switch_mode_strap, stack_two_config_strap, stack_two_config;
  wire [1:0] port_clocking_mode_strap, port_clocking_mode;
  wire [4:0] stack_three_config_strap, stack_three_config;
  wire [31:0] avs_readdata;
  wire core_reset_n, smbus_enable, reg_access_enable, quasi_reset, ref_clock_125_sel;
  wire eeprom_init, eeprom_jump_en, eeprom_jump_sel, reduced_latency, multi_partition;
  wire ports_unattached, ports_disabled, i2c_reset_mode, mode_reserved, strap_change_err;
  wire [8:0] dec = {mode_reserved, i2c_reset_mode, ports_disabled, ports_unattached,
    multi_partition, reduced_latency, eeprom_jump_sel, eeprom_jump_en, eeprom_init};
  wire [11:0] capt = {stack_three_config, stack_two_config, port_clocking_mode,
    ref_clock_125_sel};
  srms_top u_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fundamental_reset_n(fundamental_reset_n),
    .reset_halt_request(reset_halt_request),
    .switch_mode_strap(switch_mode_strap),
    .ref_clock_freq_select(ref_clock_freq_select),
    .port_clocking_mode_strap(port_clocking_mode_strap),
    .stack_two_config_strap(stack_two_config_strap),
    .stack_three_config_strap(stack_three_config_strap),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .core_reset_n(core_reset_n),
    .smbus_enable(smbus_enable),
    .reg_access_enable(reg_access_enable),
    .quasi_reset(quasi_reset),
    .ref_clock_125_sel(ref_clock_125_sel),
    .port_clocking_mode(port_clocking_mode),
    .stack_two_config(stack_two_config),
    .stack_three_config(stack_three_config),
    .eeprom_init(eeprom_init),
    .eeprom_jump_en(eeprom_jump_en),
    .eeprom_jump_sel(eeprom_jump_sel),
    .reduced_latency(reduced_latency),
    .multi_partition(multi_partition),
    .ports_unattached(ports_unattached),
    .ports_disabled(ports_disabled),
    .i2c_reset_mode(i2c_reset_mode),
    .mode_reserved(mode_reserved),
    .strap_change_err(strap_change_err)
  );
  srms_board u_board (
    .sys_clk(sys_clk),
    .hold_n(hold_n),
    .mode_live(mode_live),
    .cfg(cfg),
    .fundamental_reset_n(fundamental_reset_n),
    .reset_halt_request(reset_halt_request),
    .switch_mode_strap(switch_mode_strap),
    .ref_clock_freq_select(ref_clock_freq_select),
    .port_clocking_mode_strap(port_clocking_mode_strap),
    .stack_two_config_strap(stack_two_config_strap),
    .stack_three_config_strap(stack_three_config_strap)
  );
  always #50 sys_clk = ~sys_clk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      num_errors++;
      summarize();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task boot(input logic [16:0] c);
    hold_n <= 1'b0;
    cfg <= c;
    repeat (4) @(posedge sys_clk);
    hold_n <= 1'b1;
    repeat (9) @(posedge sys_clk);
  endtask
  initial
  begin
    tbl = '{9'h000, 9'h001, 9'h003, 9'h007, 9'h100, 9'h100, 9'h100, 9'h100,
      9'h008, 9'h009, 9'h030, 9'h031, 9'h100, 9'h0b1, 9'h050, 9'h051};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(core_reset_n, 32'h0);
    for (int i = 0; i < 16; i++)
      if (i < 4 || i > 7)
      begin
        boot({1'b0, 5'(i + 3), 4'(~i), 2'(i), 1'(i), 4'(i)});
        chk(dec, tbl[i]);
        chk(capt, cfg[15:4]);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, {15'h0, cfg});
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, {23'h0, tbl[i]});
        chk(core_reset_n, 32'h1);
      end
    cfg <= cfg ^ 17'h0_0780;
    repeat (6) @(posedge sys_clk);
    chk(stack_two_config, 32'h0);
    hold_n <= 1'b0;
    repeat (7) @(posedge sys_clk);
    chk({core_reset_n, smbus_enable, dec}, 32'h0);
    boot(17'h1_0d2b);
    chk({quasi_reset, smbus_enable, core_reset_n, reg_access_enable}, 32'hd);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h1a);
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h1_0d2b);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    chk(quasi_reset, 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk({quasi_reset, core_reset_n}, 32'h1);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h1f);
    chk(strap_change_err, 32'h0);
    mode_live <= 1'b1;
    cfg <= cfg ^ 17'h0_0001;
    repeat (6) @(posedge sys_clk);
    chk(strap_change_err, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, 4'h0, 32'h2);
    chk(strap_change_err, 32'h1);
    cfg <= cfg ^ 17'h0_0001;
    repeat (6) @(posedge sys_clk);
    bus(1'b1, 4'h0, 32'h2);
    chk(strap_change_err, 32'h0);
    summarize();
  end
endmodule
bind srms_top srms_chk #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .fundamental_reset_n(fundamental_reset_n),
  .avs_address(avs_address),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest),
  .core_reset_n(core_reset_n),
  .smbus_enable(smbus_enable),
  .quasi_reset(quasi_reset),
  .stack_two_config(stack_two_config),
  .eeprom_init(eeprom_init),
  .eeprom_jump_en(eeprom_jump_en),
  .reduced_latency(reduced_latency),
  .multi_partition(multi_partition),
  .ports_unattached(ports_unattached),
  .ports_disabled(ports_disabled),
  .i2c_reset_mode(i2c_reset_mode),
  .mode_reserved(mode_reserved)
);
`default_nettype wire
